// *** hdl/rmic_mode_ctrl.sv ***
`timescale 1ns/1ps
module rmic_mode_ctrl (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_select_pin_n,
	input wire logic i_supply_ready,
	input wire logic i_boot_done,
	input wire logic i_cal_done,
	input wire logic i_pll_settled,
	input wire logic i_rx_ready,
	input wire logic i_tx_ready,
	input wire logic i_op_done,
	input wire logic i_wake_timer,
	input wire logic [rmic_pkg::IRQ_COUNT-1:0] i_events,
	output logic o_miso,
	output logic o_miso_oe,
	output logic o_spi_inputs_en,
	output logic o_busy,
	output logic o_busy_oe,
	output logic o_busy_weak_high_bias,
	output logic o_event_pin_one,
	output logic o_event_pin_two,
	output logic o_event_pin_three,
	output logic [2:0] o_event_pin_oe,
	output logic [2:0] o_event_pin_weak_low_bias,
	output logic [2:0] o_event_three_level,
	output logic o_hard_reset_weak_high_bias,
	output rmic_pkg::rmic_mode_t o_mode,
	output logic o_slow_rc_osc_en,
	output logic o_fast_rc_osc_en,
	output logic o_crystal_osc_en,
	output logic o_dcdc_en,
	output logic o_synth_en,
	output logic o_rx_en,
	output logic o_tx_en,
	output logic o_packet_chirp,
	output logic o_cal_start,
	output logic [4:0] o_cal_blocks,
	output logic [7:0] o_band_low_code,
	output logic [7:0] o_band_high_code
);
	import rmic_pkg::*;

	// Whole state of the sequencer.
	typedef struct packed {
		rmic_mode_t mode;
		logic busy;
		logic reset_bias;
		logic [9:0] status;
		logic [9:0] enable;
		logic [9:0] map_one;
		logic [9:0] map_two;
		logic [9:0] map_three;
		logic [7:0] pad_oe;
		logic [7:0] pad_ie;
		logic [7:0] pad_pu;
		logic [7:0] pad_pd;
		logic [7:0] ref_ctl;
		logic dcdc_sel;
		logic chirp;
		logic [4:0] cal_sel;
		logic cal_go;
		logic [7:0] band_low;
		logic [7:0] band_high;
		logic [7:0] opcode;
		logic [3:0] count;
		logic [PARAM_BYTES-1:0][7:0] prm;
	} rmic_state_t;

	// Reset image: startup mode with busy high.
	localparam rmic_state_t ST_RST = '{
		mode: MD_STARTUP,
		busy: 1'b1,
		pad_oe: PAD_OE_RST,
		pad_ie: PAD_IE_RST,
		pad_pu: PAD_PU_RST,
		pad_pd: PAD_PD_RST,
		ref_ctl: REF_SUPPLY_RST,
		band_low: BAND_LOW_RST,
		band_high: BAND_HIGH_RST,
		default: '0
	};

	rmic_state_t q;
	rmic_state_t d;

	logic sel_n;         // Synchronised select level.
	logic frame_start;   // Pulse on select falling.
	logic frame_end;     // Pulse on select rising.
	logic byte_valid;    // Pulse when a byte has arrived.
	logic [7:0] rx_byte; // Byte from the host.
	logic [7:0] tx_byte; // Answer byte for the next slot.
	logic active;        // Pads are driven in this mode.
	logic manual_three;  // Third event pin under manual control.
	logic [9:0] pending; // Enabled status bits that are set.
	logic [9:0] clear;   // Status bits cleared by the host.

	// Pin engine for the four-wire serial port.
	rmic_spi_link u_link (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_sck(i_sck),
		.i_mosi(i_mosi),
		.i_select_pin_n(i_select_pin_n),
		.i_tx_byte(tx_byte),
		.o_select_n(sel_n),
		.o_frame_start(frame_start),
		.o_frame_end(frame_end),
		.o_byte_valid(byte_valid),
		.o_byte(rx_byte),
		.o_miso(o_miso)
	);

	// Sources that can fire for a mode and packet type.
	function automatic logic [9:0] allowed(input rmic_mode_t m, input logic chirp);
		logic [9:0] a;
		a = (m == MD_RX) ? IRQ_RX_SOURCES : (m == MD_TX) ? IRQ_TX_SOURCES : 10'h000;
		a = chirp ? (a & ~IRQ_FSK_ONLY) : (a & ~IRQ_CHIRP_ONLY);
		return a;
	endfunction : allowed

	// Register read decode; unmapped addresses read as zero.
	function automatic logic [7:0] reg_read(input rmic_state_t s, input logic [15:0] a);
		case (a)
			REG_PAD_OUTPUT_ENABLE: return s.pad_oe;
			REG_PAD_INPUT_ENABLE: return s.pad_ie;
			REG_PAD_PULLUP_ENABLE: return s.pad_pu;
			REG_PAD_PULLDOWN_ENABLE: return s.pad_pd;
			REG_REF_SUPPLY_CONTROL: return s.ref_ctl;
			default: return 8'h00;
		endcase
	endfunction : reg_read

	// True in the modes whose pads are actively driven.
	function automatic logic is_active(input rmic_mode_t m);
		return m inside {MD_STANDBY_FAST, MD_STANDBY_CRYSTAL, MD_SYNTH, MD_RX, MD_TX};
	endfunction : is_active

	assign active = is_active(q.mode);
	assign pending = q.status & q.enable;
	// Manual mode needs output on and input, pull-up and pull-down off.
	assign manual_three = q.pad_oe[PIN_THREE_BIT] & ~q.pad_ie[PIN_THREE_BIT]
		& ~q.pad_pu[PIN_THREE_BIT] & ~q.pad_pd[PIN_THREE_BIT];

	// Answer byte for the next slot; a read's low address byte is taken from the link as it arrives, before it is stored.
	always_comb begin
		tx_byte = {4'h0, q.mode};
		if (q.opcode == OP_READ_REG && q.count == 4'h2 && byte_valid) begin
			tx_byte = reg_read(q, {q.prm[0], rx_byte});
		end else if (q.opcode == OP_EVENT_READ && q.count == 4'h1) begin
			tx_byte = {6'h00, q.status[9:8]};
		end else if (q.opcode == OP_EVENT_READ && q.count == 4'h2) begin
			tx_byte = q.status[7:0];
		end
	end

	// Status bits cleared by a completed clear command.
	always_comb begin
		clear = 10'h000;
		if (frame_end && !q.busy && q.opcode == OP_EVENT_CLEAR && q.count >= 4'h3) begin
			clear = {q.prm[0][1:0], q.prm[1]};
		end
	end

	// Next state: byte capture, mode sequencing and command execution.
	always_comb begin
		d = q;
		d.cal_go = 1'b0;
		d.reset_bias = 1'b1;
		// Sticky status; a new event wins over a clear in the same cycle.
		d.status = (q.status & ~clear) | (i_events & q.enable & allowed(q.mode, q.chirp));
		// Capture the opcode and up to eight parameter bytes.
		if (frame_start) begin
			d.count = 4'h0;
			d.opcode = 8'h00;
		end else if (byte_valid && q.count != 4'h9) begin
			d.count = q.count + 4'h1;
			if (q.count == 4'h0) begin
				d.opcode = rx_byte;
			end else begin
				d.prm[3'(q.count - 4'h1)] = rx_byte;
			end
		end
		// Mode sequencing driven by the radio core.
		case (q.mode)
			MD_STARTUP: begin
				if (i_supply_ready && i_boot_done) begin
					d.mode = MD_CALIBRATE;
					d.cal_sel = CAL_ALL;
					d.cal_go = 1'b1;
				end
			end
			MD_CALIBRATE: begin
				if (i_cal_done && !q.cal_go) begin
					d.mode = MD_STANDBY_FAST;
					d.busy = 1'b0;
				end
			end
			MD_SLEEP: begin
				if (!sel_n || i_wake_timer) begin
					d.mode = MD_WAKE;
					// Leaving sleep restores the pad and supply defaults.
					d.pad_oe = PAD_OE_RST;
					d.pad_ie = PAD_IE_RST;
					d.pad_pu = PAD_PU_RST;
					d.pad_pd = PAD_PD_RST;
					d.ref_ctl = REF_SUPPLY_RST;
				end
			end
			MD_WAKE: begin
				if (i_supply_ready && i_boot_done) begin
					d.mode = MD_STANDBY_FAST;
					d.busy = 1'b0;
				end
			end
			MD_SYNTH: begin
				if (q.busy && i_pll_settled) begin
					d.busy = 1'b0;
				end
			end
			MD_RX: begin
				if (q.busy && i_rx_ready) begin
					d.busy = 1'b0;
				end else if (!q.busy && i_op_done) begin
					d.mode = MD_STANDBY_FAST;
				end
			end
			MD_TX: begin
				if (q.busy && i_tx_ready) begin
					d.busy = 1'b0;
				end else if (!q.busy && i_op_done) begin
					d.mode = MD_STANDBY_FAST;
				end
			end
			default: begin
			end
		endcase
		// Commands run at the end of a frame when the device is idle.
		if (frame_end && !q.busy && active && q.count != 4'h0) begin
			case (q.opcode)
				OP_WRITE_REG: begin
					if (q.count >= 4'h4) begin
						case ({q.prm[0], q.prm[1]})
							REG_PAD_OUTPUT_ENABLE: d.pad_oe = q.prm[2];
							REG_PAD_INPUT_ENABLE: d.pad_ie = q.prm[2];
							REG_PAD_PULLUP_ENABLE: d.pad_pu = q.prm[2];
							REG_PAD_PULLDOWN_ENABLE: d.pad_pd = q.prm[2];
							REG_REF_SUPPLY_CONTROL: d.ref_ctl = q.prm[2];
							default: begin
							end
						endcase
					end
				end
				OP_STANDBY_SELECT: begin
					// Parameter bit 0 low keeps the fast RC, high runs the crystal.
					d.mode = (q.count >= 4'h2 && q.prm[0][0]) ? MD_STANDBY_CRYSTAL
						: MD_STANDBY_FAST;
				end
				OP_SLEEP: begin
					if (q.mode == MD_STANDBY_FAST) begin
						d.mode = MD_SLEEP;
						d.busy = 1'b1;
					end
				end
				OP_SYNTH_HOLD: begin
					d.mode = MD_SYNTH;
					d.busy = 1'b1;
				end
				OP_RX: begin
					d.mode = MD_RX;
					d.busy = 1'b1;
				end
				OP_TX: begin
					d.mode = MD_TX;
					d.busy = 1'b1;
				end
				OP_CALIBRATE: begin
					d.mode = MD_CALIBRATE;
					d.cal_sel = q.prm[0][4:0];
					d.cal_go = 1'b1;
					d.busy = 1'b1;
				end
				OP_IMAGE_CAL: begin
					if (q.count >= 4'h3) begin
						d.band_low = q.prm[0];
						d.band_high = q.prm[1];
						d.mode = MD_CALIBRATE;
						d.cal_sel = CAL_IMAGE;
						d.cal_go = 1'b1;
						d.busy = 1'b1;
					end
				end
				OP_EVENT_ROUTING: begin
					if (q.count == 4'h9) begin
						d.enable = {q.prm[0][1:0], q.prm[1]};
						d.map_one = {q.prm[2][1:0], q.prm[3]};
						d.map_two = {q.prm[4][1:0], q.prm[5]};
						d.map_three = {q.prm[6][1:0], q.prm[7]};
					end
				end
				OP_REGULATOR_SELECT: begin
					if (q.mode == MD_STANDBY_FAST) begin
						d.dcdc_sel = q.prm[0][0];
					end
				end
				OP_PACKET_TYPE: begin
					d.chirp = q.prm[0][0];
				end
				default: begin
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	// Pads: weak biases in reset, startup, calibration, sleep and wake, driven otherwise; the reset pin pull is off in reset and on after it.
	assign o_busy = q.busy;
	assign o_busy_oe = active;
	assign o_busy_weak_high_bias = ~active;
	assign o_miso_oe = active;
	assign o_spi_inputs_en = active;
	assign o_event_pin_oe = {3{active}};
	assign o_event_pin_weak_low_bias = {3{~active}};
	assign o_hard_reset_weak_high_bias = q.reset_bias;
	// Event pins follow enabled, routed and set status bits; in manual mode the third pin follows the drive bit.
	assign o_event_pin_one = active & (|(pending & q.map_one));
	assign o_event_pin_two = active & (|(pending & q.map_two));
	assign o_event_pin_three = active & (manual_three ? q.ref_ctl[REF_DRIVE_BIT]
		: (|(pending & q.map_three)));
	assign o_event_three_level = q.ref_ctl[REF_LEVEL_MSB:REF_LEVEL_LSB];

	// Resources enabled per mode.
	assign o_mode = q.mode;
	assign o_slow_rc_osc_en = (q.mode == MD_SLEEP);
	assign o_fast_rc_osc_en = (q.mode != MD_SLEEP);
	assign o_crystal_osc_en = q.mode inside {MD_CALIBRATE, MD_STANDBY_CRYSTAL, MD_SYNTH,
		MD_RX, MD_TX};
	assign o_dcdc_en = q.dcdc_sel & (q.mode inside {MD_STANDBY_CRYSTAL, MD_SYNTH,
		MD_RX, MD_TX});
	assign o_synth_en = q.mode inside {MD_SYNTH, MD_RX, MD_TX};
	assign o_rx_en = (q.mode == MD_RX);
	assign o_tx_en = (q.mode == MD_TX);
	assign o_packet_chirp = q.chirp;
	assign o_cal_start = q.cal_go;
	assign o_cal_blocks = q.cal_sel;
	assign o_band_low_code = q.band_low;
	assign o_band_high_code = q.band_high;
endmodule : rmic_mode_ctrl

// *** hdl/rmic_pkg.sv ***
package rmic_pkg;
	// Register offsets on the serial register space.
	localparam logic [15:0] REG_PAD_OUTPUT_ENABLE = 16'h0580;
	localparam logic [15:0] REG_PAD_INPUT_ENABLE = 16'h0583;
	localparam logic [15:0] REG_PAD_PULLUP_ENABLE = 16'h0584;
	localparam logic [15:0] REG_PAD_PULLDOWN_ENABLE = 16'h0585;
	localparam logic [15:0] REG_REF_SUPPLY_CONTROL = 16'h0920;
	// Reset values of the pad and supply registers.
	localparam logic [7:0] PAD_OE_RST = 8'h00;
	localparam logic [7:0] PAD_IE_RST = 8'h0F;
	localparam logic [7:0] PAD_PU_RST = 8'h00;
	localparam logic [7:0] PAD_PD_RST = 8'h0F;
	localparam logic [7:0] REF_SUPPLY_RST = 8'h00;
	// Bit of the pad registers that belongs to the third event pin.
	localparam int PIN_THREE_BIT = 3;
	// Level field of the supply control register and the manual level bit.
	localparam int REF_LEVEL_LSB = 0;
	localparam int REF_LEVEL_MSB = 2;
	localparam int REF_DRIVE_BIT = 3;
	// Level code that gives a 3.0 V high level on the third event pin.
	localparam logic [2:0] REF_LEVEL_3V0 = 3'h6;
	// Interrupt status word layout.
	localparam int IRQ_COUNT = 10;
	localparam int IRQ_TX_COMPLETE = 0;
	localparam int IRQ_RX_COMPLETE = 1;
	localparam int IRQ_PREAMBLE_FOUND = 2;
	localparam int IRQ_SYNC_PATTERN_OK = 3;
	localparam int IRQ_HEADER_OK = 4;
	localparam int IRQ_HEADER_CRC_FAIL = 5;
	localparam int IRQ_PAYLOAD_CRC_FAIL = 6;
	localparam int IRQ_ACTIVITY_SCAN_DONE = 7;
	localparam int IRQ_ACTIVITY_FOUND = 8;
	localparam int IRQ_TIMEOUT = 9;
	// Source groups: chirp only, frequency-shift only, receive and transmit sources.
	localparam logic [9:0] IRQ_CHIRP_ONLY = 10'h1B0;
	localparam logic [9:0] IRQ_FSK_ONLY = 10'h008;
	localparam logic [9:0] IRQ_RX_SOURCES = 10'h3FE;
	localparam logic [9:0] IRQ_TX_SOURCES = 10'h201;
	// Calibration block select: slow RC, fast RC, PLL, receive ADC, image.
	localparam logic [4:0] CAL_ALL = 5'h1F;
	localparam logic [4:0] CAL_IMAGE = 5'h10;
	// Default image calibration band codes.
	localparam logic [7:0] BAND_LOW_RST = 8'hE1;
	localparam logic [7:0] BAND_HIGH_RST = 8'hE9;
	// Command opcodes of the serial port.
	localparam logic [7:0] OP_WRITE_REG = 8'h01;
	localparam logic [7:0] OP_READ_REG = 8'h02;
	localparam logic [7:0] OP_STANDBY_SELECT = 8'h03;
	localparam logic [7:0] OP_SLEEP = 8'h04;
	localparam logic [7:0] OP_SYNTH_HOLD = 8'h05;
	localparam logic [7:0] OP_TX = 8'h06;
	localparam logic [7:0] OP_RX = 8'h07;
	localparam logic [7:0] OP_CALIBRATE = 8'h08;
	localparam logic [7:0] OP_IMAGE_CAL = 8'h09;
	localparam logic [7:0] OP_EVENT_ROUTING = 8'h0A;
	localparam logic [7:0] OP_EVENT_READ = 8'h0B;
	localparam logic [7:0] OP_EVENT_CLEAR = 8'h0C;
	localparam logic [7:0] OP_REGULATOR_SELECT = 8'h0D;
	localparam logic [7:0] OP_PACKET_TYPE = 8'h0E;
	// Number of parameter bytes kept per command.
	localparam int PARAM_BYTES = 8;
	// Operating modes of the sequencer.
	typedef enum logic [3:0] {
		MD_STARTUP,
		MD_CALIBRATE,
		MD_SLEEP,
		MD_WAKE,
		MD_STANDBY_FAST,
		MD_STANDBY_CRYSTAL,
		MD_SYNTH,
		MD_RX,
		MD_TX
	} rmic_mode_t;
endpackage : rmic_pkg

// *** hdl/rmic_spi_link.sv ***
`timescale 1ns/1ps
// Serial port byte engine, sampling the link pins on the system clock.
module rmic_spi_link (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_select_pin_n,
	input wire logic [7:0] i_tx_byte,
	output logic o_select_n,
	output logic o_frame_start,
	output logic o_frame_end,
	output logic o_byte_valid,
	output logic [7:0] o_byte,
	output logic o_miso
);
	import rmic_pkg::*;

	// Whole state of the link engine.
	typedef struct packed {
		logic [2:0] sck;
		logic [2:0] sel;
		logic [1:0] mosi;
		logic [7:0] shift_in;
		logic [7:0] shift_out;
		logic [2:0] bits;
		logic load;
		logic start;
		logic stop;
		logic valid;
		logic [7:0] data;
	} rmic_link_t;

	localparam rmic_link_t LINK_RST = '{sel: 3'h7, default: '0};

	rmic_link_t q;
	rmic_link_t d;

	// Next state: synchronise, find edges, shift bytes in and out.
	always_comb begin
		d = q;
		d.sck = {q.sck[1:0], i_sck};
		d.sel = {q.sel[1:0], i_select_pin_n};
		d.mosi = {q.mosi[0], i_mosi};
		d.start = 1'b0;
		d.stop = 1'b0;
		d.valid = 1'b0;
		d.load = 1'b0;
		// A pending load takes the next answer byte from the sequencer.
		if (q.load) begin
			d.shift_out = i_tx_byte;
		end
		if (q.sel[2] && !q.sel[1]) begin
			// Select fell: restart the bit count and fetch the first answer.
			d.start = 1'b1;
			d.bits = 3'h0;
			d.load = 1'b1;
		end else if (!q.sel[2] && q.sel[1]) begin
			// Select rose: the frame ends and the command may run.
			d.stop = 1'b1;
		end else if (!q.sel[1]) begin
			if (!q.sck[2] && q.sck[1]) begin
				// Rising clock edge samples the host data.
				d.shift_in = {q.shift_in[6:0], q.mosi[1]};
				d.bits = q.bits + 3'h1;
				if (q.bits == 3'h7) begin
					d.valid = 1'b1;
					d.data = {q.shift_in[6:0], q.mosi[1]};
					d.load = 1'b1;
				end
			end else if (q.sck[2] && !q.sck[1] && q.bits != 3'h0) begin
				// Falling edge inside a byte moves the next answer bit out.
				d.shift_out = {q.shift_out[6:0], 1'b0};
			end
		end
	end

	// State register.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= LINK_RST;
		end else begin
			q <= d;
		end
	end

	assign o_select_n = q.sel[1];
	assign o_frame_start = q.start;
	assign o_frame_end = q.stop;
	assign o_byte_valid = q.valid;
	assign o_byte = q.data;
	assign o_miso = q.shift_out[7];
endmodule : rmic_spi_link

// *** tb/rmic_host_model.sv ***
`timescale 1ns/1ps
// Host controller: mode 0 frames on a 160 ns link clock, gated by busy.
module rmic_host_model (
	input wire logic i_clk,
	input wire logic i_busy,
	input wire logic i_miso,
	output logic o_sck,
	output logic o_mosi,
	output logic o_select_n
);
	import rmic_pkg::*;
	logic [7:0] tx_q[$]; // Bytes to send, opcode first.
	logic [7:0] rx_q[$]; // Bytes returned, one per byte sent.
	// The link clock stands still low outside frames.
	initial begin
		o_sck = 1'b0;
		o_mosi = 1'b0;
		o_select_n = 1'b1;
	end
	// Sends tx_q as one frame once busy is seen low, or after 20000 clocks at most.
	task automatic frame();
		logic [7:0] r;
		int n;
		n = 0;
		while (i_busy !== 1'b0 && n < 20000) begin
			@(posedge i_clk);
			n++;
		end
		rx_q = {};
		@(posedge i_clk);
		#1 o_select_n = 1'b0;
		foreach (tx_q[i]) begin
			for (int k = 7; k >= 0; k--) begin
				o_mosi = tx_q[i][k];
				#80 o_sck = 1'b1;
				r = {r[6:0], i_miso};
				#80 o_sck = 1'b0;
			end
			rx_q.push_back(r);
		end
		#80 o_select_n = 1'b1;
		// Released data line shows the inverse so stale bits cannot pass.
		o_mosi = ~o_mosi;
		repeat (10) @(posedge i_clk);
	endtask : frame
	// Pulls select low for a while without clocking, to wake the device.
	task automatic wake();
		@(posedge i_clk);
		#1 o_select_n = 1'b0;
		repeat (20) @(posedge i_clk);
		#1 o_select_n = 1'b1;
	endtask : wake
endmodule : rmic_host_model

// *** tb/rmic_mode_ctrl_props.sv ***
`timescale 1ns/1ps
// Watches pad setup, busy and mode sequencing at the controller's ports.
module rmic_mode_ctrl_props (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_supply_ready,
	input wire logic i_boot_done,
	input wire logic i_cal_done,
	input wire logic i_pll_settled,
	input wire logic o_busy,
	input wire logic o_busy_oe,
	input wire logic o_busy_weak_high_bias,
	input wire logic o_miso_oe,
	input wire logic o_spi_inputs_en,
	input wire logic [2:0] o_event_pin_oe,
	input wire logic [2:0] o_event_pin_weak_low_bias,
	input wire logic o_hard_reset_weak_high_bias,
	input wire rmic_pkg::rmic_mode_t o_mode,
	input wire logic o_fast_rc_osc_en,
	input wire logic o_crystal_osc_en,
	input wire logic o_rx_en,
	input wire logic o_tx_en,
	input wire logic o_cal_start,
	input wire logic [4:0] o_cal_blocks
);
	import rmic_pkg::*;
	// Modes that park the pads, and modes that drive them.
	wire low_md = o_mode inside {MD_STARTUP, MD_CALIBRATE, MD_SLEEP, MD_WAKE};
	wire act_md = o_mode inside {MD_STANDBY_FAST, MD_STANDBY_CRYSTAL, MD_SYNTH, MD_RX, MD_TX};
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	property p_low_pads;
		low_md |-> o_event_pin_oe == 3'h0 && o_event_pin_weak_low_bias == 3'h7
			&& o_busy_weak_high_bias && !o_busy_oe && !o_miso_oe && !o_spi_inputs_en;
	endproperty
	a_low_pads: assert property (p_low_pads) else $error("pads not parked");
	property p_act_pads;
		act_md |-> o_event_pin_oe == 3'h7 && o_event_pin_weak_low_bias == 3'h0 && o_busy_oe
			&& o_miso_oe && o_spi_inputs_en && !o_busy_weak_high_bias;
	endproperty
	a_act_pads: assert property (p_act_pads) else $error("pads not driven");
	property p_reset_pull;
		$past(i_rst_n) |-> o_hard_reset_weak_high_bias;
	endproperty
	a_reset_pull: assert property (p_reset_pull) else $error("reset pin unpulled");
	property p_startup;
		o_mode == MD_STARTUP && !(i_supply_ready && i_boot_done) |-> o_busy ##1 o_mode == MD_STARTUP;
	endproperty
	a_startup: assert property (p_startup) else $error("startup left early");
	property p_cal_start;
		o_mode == MD_STARTUP && i_supply_ready && i_boot_done
			|-> ##[1:2] (o_cal_start && o_cal_blocks == CAL_ALL);
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("no full calibration");
	property p_cal_end;
		o_mode == MD_CALIBRATE && i_cal_done && !o_cal_start |-> ##[1:2] o_mode == MD_STANDBY_FAST;
	endproperty
	a_cal_end: assert property (p_cal_end) else $error("calibration end wrong");
	property p_sleep_busy;
		o_mode == MD_SLEEP |-> o_busy;
	endproperty
	a_sleep_busy: assert property (p_sleep_busy) else $error("busy low in sleep");
	property p_sleep_entry;
		$rose(o_mode == MD_SLEEP) |-> $past(o_mode) == MD_STANDBY_FAST;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("bad sleep entry");
	property p_synth;
		(o_mode == MD_SYNTH && i_pll_settled) [*3] |-> !o_busy;
	endproperty
	a_synth: assert property (p_synth) else $error("busy after lock");
	property p_fast_res;
		o_mode == MD_STANDBY_FAST |-> o_fast_rc_osc_en && !o_crystal_osc_en && !o_rx_en && !o_tx_en;
	endproperty
	a_fast_res: assert property (p_fast_res) else $error("fast standby resources");
endmodule : rmic_mode_ctrl_props

bind rmic_mode_ctrl rmic_mode_ctrl_props u_props (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_supply_ready(i_supply_ready),
	.i_boot_done(i_boot_done), .i_cal_done(i_cal_done), .i_pll_settled(i_pll_settled),
	.o_busy(o_busy), .o_busy_oe(o_busy_oe), .o_busy_weak_high_bias(o_busy_weak_high_bias),
	.o_miso_oe(o_miso_oe), .o_spi_inputs_en(o_spi_inputs_en), .o_event_pin_oe(o_event_pin_oe),
	.o_event_pin_weak_low_bias(o_event_pin_weak_low_bias),
	.o_hard_reset_weak_high_bias(o_hard_reset_weak_high_bias), .o_mode(o_mode),
	.o_fast_rc_osc_en(o_fast_rc_osc_en), .o_crystal_osc_en(o_crystal_osc_en),
	.o_rx_en(o_rx_en), .o_tx_en(o_tx_en), .o_cal_start(o_cal_start), .o_cal_blocks(o_cal_blocks)
);

// *** tb/rmic_mode_ctrl_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench: host frames, event pulses and mode sequencing.
module rmic_mode_ctrl_tb;
	import rmic_pkg::*;
	logic clk, rst_n, supply, boot, cal_done, pll, rx_rdy, tx_rdy, op_done, wake_tmr;
	logic [9:0] events;
	logic sck, mosi, sel_n, miso, miso_oe, miso_hold, busy, busy_oe, busy_pu, busy_w;
	logic e1, e2, e3, hr_pu, crystal_osc, dcdc, cal_start, slow_rc, synth_on, pkt_chirp;
	logic [2:0] ev_oe, ev_pd, level;
	logic [4:0] cal_blocks, last_cal;
	logic [7:0] band_lo, band_hi, d;
	rmic_mode_t mode;
	int n_fail, n_tests;
	// Register map walked for reset values.
	logic [15:0] ra[5] = '{REG_PAD_OUTPUT_ENABLE, REG_PAD_INPUT_ENABLE, REG_PAD_PULLUP_ENABLE,
		REG_PAD_PULLDOWN_ENABLE, REG_REF_SUPPLY_CONTROL};
	logic [7:0] rv[5] = '{PAD_OE_RST, PAD_IE_RST, PAD_PU_RST, PAD_PD_RST, REF_SUPPLY_RST};
	// Undriven lines: busy falls to its pull, MISO shows the inverse of its last bit.
	assign busy_w = busy_oe ? busy : busy_pu;
	assign miso = miso_oe ? miso_hold : ~miso_hold;
	rmic_mode_ctrl u_dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_sck(sck), .i_mosi(mosi), .i_select_pin_n(sel_n),
		.i_supply_ready(supply), .i_boot_done(boot), .i_cal_done(cal_done), .i_pll_settled(pll),
		.i_rx_ready(rx_rdy), .i_tx_ready(tx_rdy), .i_op_done(op_done), .i_wake_timer(wake_tmr),
		.i_events(events), .o_miso(miso_hold), .o_miso_oe(miso_oe), .o_spi_inputs_en(),
		.o_busy(busy), .o_busy_oe(busy_oe), .o_busy_weak_high_bias(busy_pu),
		.o_event_pin_one(e1), .o_event_pin_two(e2), .o_event_pin_three(e3),
		.o_event_pin_oe(ev_oe), .o_event_pin_weak_low_bias(ev_pd), .o_event_three_level(level),
		.o_hard_reset_weak_high_bias(hr_pu), .o_mode(mode), .o_slow_rc_osc_en(slow_rc),
		.o_fast_rc_osc_en(), .o_crystal_osc_en(crystal_osc), .o_dcdc_en(dcdc), .o_synth_en(synth_on),
		.o_rx_en(), .o_tx_en(), .o_packet_chirp(pkt_chirp), .o_cal_start(cal_start),
		.o_cal_blocks(cal_blocks), .o_band_low_code(band_lo), .o_band_high_code(band_hi)
	);
	rmic_host_model u_host (
		.i_clk(clk), .i_busy(busy_w), .i_miso(miso), .o_sck(sck), .o_mosi(mosi), .o_select_n(sel_n)
	);
	// The clock toggles every half period.
	always #5 clk = ~clk;
	// Keeps the block select of the last calibration start.
	always @(posedge clk) if (cal_start === 1'b1) last_cal <= cal_blocks;
	// Compares one value and counts the outcome.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Prints the verdict and ends the run.
	task automatic complete_run();
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	// Opcode with one parameter byte.
	task automatic op(input logic [7:0] o, input logic [7:0] p);
		u_host.tx_q = '{o, p};
		u_host.frame();
	endtask : op
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		u_host.tx_q = '{OP_WRITE_REG, a[15:8], a[7:0], v};
		u_host.frame();
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		u_host.tx_q = '{OP_READ_REG, a[15:8], a[7:0], 8'h00};
		u_host.frame();
		v = u_host.rx_q[3];
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	// Routes sources by index mod three, pulses each source, reads and clears status.
	task automatic ev_pass(input logic [7:0] mop, input logic chirp, input logic [9:0] en,
		input logic [9:0] allow);
		logic [9:0] st, ex;
		op(OP_STANDBY_SELECT, 8'h00);
		op(OP_PACKET_TYPE, {7'h00, chirp});
		check(16'(pkt_chirp), 16'(chirp));
		u_host.tx_q = '{OP_EVENT_ROUTING, {6'h00, en[9:8]}, en[7:0], 8'h02, 8'h49, 8'h00, 8'h92,
			8'h01, 8'h24};
		u_host.frame();
		op(mop, 8'h00);
		for (int k = 0; k < IRQ_COUNT; k++) begin
			settle(1);
			events[k] = 1'b1;
			settle(1);
			events[k] = 1'b0;
			u_host.tx_q = '{OP_EVENT_READ, 8'h00, 8'h00, 8'h00};
			u_host.frame();
			st = {u_host.rx_q[2][1:0], u_host.rx_q[3]};
			ex = en & allow & (10'h001 << k);
			check(16'(st), 16'(ex));
			check(16'({e3, e2, e1}), 16'((ex != 10'h000) ? (3'h1 << (k % 3)) : 3'h0));
			u_host.tx_q = '{OP_EVENT_CLEAR, 8'h03, 8'hFF};
			u_host.frame();
		end
	endtask : ev_pass
	// Gives up when the run takes far longer than planned.
	initial begin
		#1_000_000;
		n_fail++;
		complete_run();
	end
	initial begin
		{clk, rst_n, supply, boot, cal_done, pll, rx_rdy, tx_rdy, op_done, wake_tmr} = 10'h000;
		events = 10'h000;
		n_fail = 0;
		n_tests = 0;
		settle(10);
		check(16'({mode, busy_w, hr_pu, ev_oe, ev_pd}), 16'({MD_STARTUP, 2'b10, 3'h0, 3'h7}));
		rst_n = 1'b1;
		settle(20);
		check(16'({mode, busy_w}), 16'({MD_STARTUP, 1'b1}));
		supply = 1'b1;
		boot = 1'b1;
		settle(3);
		cal_done = 1'b1;
		settle(5);
		check(16'({mode, busy_w, last_cal}), 16'({MD_STANDBY_FAST, 1'b0, CAL_ALL}));
		check({band_lo, band_hi}, {BAND_LOW_RST, BAND_HIGH_RST});
		for (int i = 0; i < 5; i++) begin
			rd(ra[i], d);
			check(16'(d), 16'(rv[i]));
		end
		op(OP_CALIBRATE, 8'h10);
		settle(5);
		check(16'({mode, last_cal}), 16'({MD_STANDBY_FAST, CAL_IMAGE}));
		u_host.tx_q = '{OP_IMAGE_CAL, 8'h6B, 8'h6F};
		u_host.frame();
		check({band_lo, band_hi}, 16'h6B6F);
		op(OP_REGULATOR_SELECT, 8'h01);
		op(OP_STANDBY_SELECT, 8'h01);
		settle(5);
		check(16'({mode, crystal_osc, dcdc}), 16'({MD_STANDBY_CRYSTAL, 2'b11}));
		op(OP_SYNTH_HOLD, 8'h00);
		settle(20);
		check(16'({mode, busy_w, synth_on}), 16'({MD_SYNTH, 2'b11}));
		{pll, rx_rdy, tx_rdy} = 3'h7;
		settle(50);
		check(16'({mode, busy_w}), 16'({MD_SYNTH, 1'b0}));
		op(OP_SLEEP, 8'h00);
		check(16'(mode), 16'(MD_SYNTH));
		op(OP_STANDBY_SELECT, 8'h00);
		// Manual drive of the third event pin.
		rd(REG_PAD_OUTPUT_ENABLE, d);
		wr(REG_PAD_OUTPUT_ENABLE, d | 8'h08);
		for (int i = 1; i < 4; i++) begin
			rd(ra[i], d);
			wr(ra[i], d & 8'hF7);
		end
		wr(REG_REF_SUPPLY_CONTROL, 8'h06);
		check(16'({level, e3}), 16'({REF_LEVEL_3V0, 1'b0}));
		wr(REG_REF_SUPPLY_CONTROL, 8'h0E);
		check(16'(e3), 16'h0001);
		// Reference supply is now on, so the host asks for a complete calibration.
		op(OP_CALIBRATE, 8'h1F);
		settle(5);
		check(16'({mode, last_cal}), 16'({MD_STANDBY_FAST, CAL_ALL}));
		op(OP_SLEEP, 8'h00);
		settle(5);
		check(16'({mode, busy_w, slow_rc}), 16'({MD_SLEEP, 2'b11}));
		u_host.wake();
		rd(REG_PAD_OUTPUT_ENABLE, d);
		check(16'({mode, d, e3}), 16'({MD_STANDBY_FAST, PAD_OE_RST, 1'b0}));
		ev_pass(OP_RX, 1'b0, 10'h3FD, IRQ_RX_SOURCES & ~IRQ_CHIRP_ONLY);
		ev_pass(OP_RX, 1'b1, 10'h3FF, IRQ_RX_SOURCES & ~IRQ_FSK_ONLY);
		ev_pass(OP_TX, 1'b0, 10'h3FF, IRQ_TX_SOURCES & ~IRQ_CHIRP_ONLY);
		op_done = 1'b1;
		settle(1);
		op_done = 1'b0;
		settle(5);
		check(16'(mode), 16'(MD_STANDBY_FAST));
		op(OP_SLEEP, 8'h00);
		settle(5);
		wake_tmr = 1'b1;
		settle(1);
		wake_tmr = 1'b0;
		settle(20);
		check(16'({mode, busy_w}), 16'({MD_STANDBY_FAST, 1'b0}));
		complete_run();
	end
endmodule : rmic_mode_ctrl_tb
